// [rtl/sfrl_top.sv]
// Shift queue readback loop with host register port
//
// Local design decisions: the address-and-strobe port and the register addresses.
module sfrl_top (
    input wire logic CLOCK,
    input wire logic ARST_N,
    input wire logic [sfrl_pkg::AW-1:0] REG_ADDR,
    input wire logic [sfrl_pkg::DW-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [sfrl_pkg::DW-1:0] REG_RDATA,
    input wire logic LINK_CLK,
    input wire logic LINK_TDI,
    output logic LINK_TDO
);
    // ------------------------------------------------------------
    // Host side registers
    // ------------------------------------------------------------
    logic [sfrl_pkg::DW-1:0] cfg_r;
    logic [sfrl_pkg::DW-1:0] cnt_r;
    logic start_tgl_r;
    logic busy_r;
    logic done_r;
    logic done_seen_r;
    logic [sfrl_pkg::QW-1:0] cap_copy_r;
    logic [sfrl_pkg::QW-1:0] cap_r;
    logic done_s;
    logic busy_nxt;
    logic done_nxt;

    wire logic wr_cfg = REG_WR && REG_ADDR == sfrl_pkg::ADDR_CFG;
    wire logic wr_cnt = REG_WR && REG_ADDR == sfrl_pkg::ADDR_CNT;
    wire logic wr_cmd = REG_WR && REG_ADDR == sfrl_pkg::ADDR_CMD;
    wire logic [3:0] cmd_type = REG_WDATA[sfrl_pkg::CMD_TYPE +: 4];
    wire logic [2:0] cmd_start = REG_WDATA[sfrl_pkg::CMD_START +: 3];
    wire logic [3:0] cmd_flag = REG_WDATA[sfrl_pkg::CMD_FLAG +: 4];
    wire logic scan_go = wr_cmd && !busy_r
        && cmd_type == sfrl_pkg::TYPE_CTRL
        && cmd_start == sfrl_pkg::START_SCAN;
    wire logic flag_clr = wr_cmd
        && cmd_flag == sfrl_pkg::FLAG_CLEAR;
    wire logic done_evt = done_s != done_seen_r;

    // Completion wins over a clear in the same cycle
    assign done_nxt = done_evt || (done_r && !flag_clr);
    assign busy_nxt = scan_go || (busy_r && !done_evt);

    wire logic [sfrl_pkg::DW-1:0] stat_val =
        sfrl_pkg::DW'({done_r, busy_r});
    wire logic [sfrl_pkg::DW-1:0] rd_val =
        REG_ADDR == sfrl_pkg::ADDR_CFG ? cfg_r :
        REG_ADDR == sfrl_pkg::ADDR_CNT ? cnt_r :
        REG_ADDR == sfrl_pkg::ADDR_STAT ? stat_val :
        REG_ADDR == sfrl_pkg::ADDR_CAPL ?
            cap_copy_r[sfrl_pkg::QH-1:0] :
        REG_ADDR == sfrl_pkg::ADDR_CAPH ?
            cap_copy_r[sfrl_pkg::QW-1:sfrl_pkg::QH] :
        '0;

    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            cfg_r <= sfrl_pkg::CFG_RESET;
            cnt_r <= sfrl_pkg::CNT_RESET;
        end else begin
            if (wr_cfg) begin
                cfg_r <= REG_WDATA & sfrl_pkg::CFG_MASK;
            end
            if (wr_cnt) begin
                cnt_r <= REG_WDATA;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            start_tgl_r <= 1'b0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            done_seen_r <= 1'b0;
        end else begin
            start_tgl_r <= start_tgl_r ^ scan_go;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
            done_seen_r <= done_s;
        end
    end

    // Capture buffer stays still in the link domain until next start
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            cap_copy_r <= sfrl_pkg::CAP_RESET;
        end else if (done_evt) begin
            cap_copy_r <= cap_r;
        end
    end

    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            REG_RDATA <= '0;
        end else if (REG_RD) begin
            REG_RDATA <= rd_val;
        end else begin
            REG_RDATA <= '0;
        end
    end

    // ------------------------------------------------------------
    // Crossings into the link domain
    // ------------------------------------------------------------
    logic [sfrl_pkg::DW-1:0] cfg_l;
    logic [sfrl_pkg::DW-1:0] cnt_l;
    logic start_l;
    logic tdi_rise;

    sfrl_sync #(.W(sfrl_pkg::DW)) u_cfg_sync (
        .clk(LINK_CLK), .rst_n(ARST_N), .d(cfg_r), .q(cfg_l));
    sfrl_sync #(.W(sfrl_pkg::DW)) u_cnt_sync (
        .clk(LINK_CLK), .rst_n(ARST_N), .d(cnt_r), .q(cnt_l));
    sfrl_sync #(.W(1)) u_start_sync (
        .clk(LINK_CLK), .rst_n(ARST_N), .d(start_tgl_r), .q(start_l));
    sfrl_sync #(.W(1)) u_tdi_sync (
        .clk(LINK_CLK), .rst_n(ARST_N), .d(LINK_TDI), .q(tdi_rise));

    // ------------------------------------------------------------
    // Link domain
    // ------------------------------------------------------------
    sfrl_pkg::sfrl_link_t st_r;
    sfrl_pkg::sfrl_link_t st_nxt;
    logic start_seen_r;
    logic [sfrl_pkg::IW-1:0] idx_r;
    logic [sfrl_pkg::IW-1:0] lim_r;
    logic start_d_r;
    logic done_tgl_r;
    logic tdi_fall1_r;
    logic tdi_fall2_r;
    logic [sfrl_pkg::DLYD-1:0] dly_r;
    logic [sfrl_pkg::QW-1:0] q;
    logic q_out;
    logic [sfrl_pkg::QW-1:0] snap_r;

    wire logic [sfrl_pkg::DLYW-1:0] dly_sel =
        cfg_l[sfrl_pkg::CFG_DLY +: sfrl_pkg::DLYW];
    wire logic len_long = cfg_l[sfrl_pkg::CFG_LEN];
    wire logic [1:0] src_sel = cfg_l[sfrl_pkg::CFG_SRC +: 2];
    wire logic [1:0] out_sel = cfg_l[sfrl_pkg::CFG_SEL +: 2];
    wire logic post_copy = cfg_l[sfrl_pkg::CFG_POST];
    wire logic msb_first = cfg_l[sfrl_pkg::CFG_MSB];
    wire logic edge_late = cfg_l[sfrl_pkg::CFG_EDGE];
    wire logic shifting = st_r == sfrl_pkg::SFRL_SHIFT;
    wire logic start_evt = start_d_r != start_seen_r;
    wire logic last_bit = shifting && idx_r == lim_r;

    // Leading edge sample unless the late edge is chosen
    wire logic tdi_pin = edge_late ? tdi_fall2_r : tdi_rise;
    // Zero delay field bypasses the compensation line
    wire logic tdi_eff = dly_sel == '0 ? tdi_pin :
        dly_r[dly_sel - 1'b1];
    wire logic q_in = src_sel == sfrl_pkg::SRC_LOOP ?
        q_out : tdi_eff;

    sfrl_queue u_queue (
        .clk(LINK_CLK),
        .rst_n(ARST_N),
        .shift(shifting),
        .long_sel(len_long),
        .msb_first(msb_first),
        .din(q_in),
        .q(q),
        .dout(q_out)
    );

    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            sfrl_pkg::SFRL_IDLE: begin
                if (start_evt) begin
                    st_nxt = sfrl_pkg::SFRL_SHIFT;
                end
            end
            sfrl_pkg::SFRL_SHIFT: begin
                if (last_bit) begin
                    st_nxt = sfrl_pkg::SFRL_IDLE;
                end
            end
        endcase
    end

    // Late edge sample, then retimed onto the rising edge
    always_ff @(negedge LINK_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            tdi_fall1_r <= 1'b0;
        end else begin
            tdi_fall1_r <= LINK_TDI;
        end
    end

    always_ff @(posedge LINK_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            tdi_fall2_r <= 1'b0;
            dly_r <= '0;
        end else begin
            tdi_fall2_r <= tdi_fall1_r;
            dly_r <= {dly_r[sfrl_pkg::DLYD-2:0], tdi_pin};
        end
    end

    always_ff @(posedge LINK_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            st_r <= sfrl_pkg::SFRL_IDLE;
            start_seen_r <= 1'b0;
            start_d_r <= 1'b0;
            idx_r <= '0;
            lim_r <= '0;
            done_tgl_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            start_d_r <= start_l;
            start_seen_r <= start_d_r;
            if (!shifting && start_evt) begin
                idx_r <= '0;
                lim_r <= cnt_l[sfrl_pkg::IW-1:0];
            end else if (shifting) begin
                idx_r <= idx_r + 1'b1;
            end
            done_tgl_r <= done_tgl_r ^ last_bit;
        end
    end

    // Each bit leaving the queue lands in the capture buffer
    always_ff @(posedge LINK_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cap_r <= sfrl_pkg::CAP_RESET;
        end else if (shifting) begin
            cap_r[idx_r] <= q_out;
        end
    end

    // Data output follows the queue head when SEL_QUEUE is selected, or waits for the copy; any other select holds it high
    always_ff @(posedge LINK_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            LINK_TDO <= 1'b1;
        end else if (out_sel != sfrl_pkg::SEL_QUEUE) begin
            LINK_TDO <= 1'b1;
        end else if (!post_copy || shifting) begin
            LINK_TDO <= q_out;
        end
    end

    always_ff @(posedge LINK_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            snap_r <= sfrl_pkg::QUEUE_RESET;
        end else if (!shifting && start_evt) begin
            snap_r <= q;
        end
    end

    sfrl_sync #(.W(1)) u_done_sync (
        .clk(CLOCK), .rst_n(ARST_N), .d(done_tgl_r), .q(done_s));

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    wire logic [sfrl_pkg::IW:0] turn_len = len_long ?
        (sfrl_pkg::IW+1)'(sfrl_pkg::QW) : (sfrl_pkg::IW+1)'(sfrl_pkg::QH);
    wire logic full_turn = ({1'b0, lim_r} + 1'b1) == turn_len;

    chk_loop_feed: assert property (
        @(posedge LINK_CLK) disable iff (!ARST_N)
        shifting && src_sel == sfrl_pkg::SRC_LOOP |-> q_in == q_out)
        else $error("loopback input differs from queue output");

    chk_shift_count: assert property (
        @(posedge LINK_CLK) disable iff (!ARST_N)
        shifting |=> shifting == !$past(last_bit))
        else $error("shift count differs from programmed count");

    chk_shift_start: assert property (
        @(posedge LINK_CLK) disable iff (!ARST_N)
        !shifting && start_evt |=> shifting && idx_r == '0)
        else $error("scan did not start from first position");

    chk_capture_copy: assert property (
        @(posedge LINK_CLK) disable iff (!ARST_N)
        shifting |=> cap_r[$past(idx_r)] == $past(q_out))
        else $error("exiting bit not copied to capture buffer");

    chk_queue_restore: assert property (
        @(posedge LINK_CLK) disable iff (!ARST_N)
        last_bit && full_turn && src_sel == sfrl_pkg::SRC_LOOP
            |=> q == snap_r)
        else $error("queue changed by a full readback");

    chk_tdo_source: assert property (
        @(posedge LINK_CLK) disable iff (!ARST_N)
        out_sel == sfrl_pkg::SEL_QUEUE && !post_copy
            && $stable(cfg_l) |=> LINK_TDO == $past(q_out))
        else $error("data output not taken from queue");

    chk_post_hold: assert property (
        @(posedge LINK_CLK) disable iff (!ARST_N)
        !shifting && post_copy && $stable(cfg_l)
            && out_sel == sfrl_pkg::SEL_QUEUE |=> $stable(LINK_TDO))
        else $error("data sent before queue copied");

    chk_lsb_first: assert property (
        @(posedge LINK_CLK) disable iff (!ARST_N)
        !msb_first |-> q_out == q[0])
        else $error("bit order not LSB first");

    chk_edge_rise: assert property (
        @(posedge LINK_CLK) disable iff (!ARST_N)
        !edge_late |-> tdi_pin == tdi_rise)
        else $error("input not sampled on leading edge");

    chk_len_short: assert property (
        @(posedge LINK_CLK) disable iff (!ARST_N)
        shifting && !len_long |=> $stable(q[sfrl_pkg::QW-1:sfrl_pkg::QH]))
        else $error("short queue touched upper half");

    chk_scan_start: assert property (
        @(posedge CLOCK) disable iff (!ARST_N)
        scan_go |=> busy_r && start_tgl_r != $past(start_tgl_r))
        else $error("start command did not begin scan");

    chk_done_copy: assert property (
        @(posedge CLOCK) disable iff (!ARST_N)
        done_evt |=> done_r && !busy_r && cap_copy_r == $past(cap_r))
        else $error("capture copy missing at scan end");

    chk_flag_clear: assert property (
        @(posedge CLOCK) disable iff (!ARST_N)
        flag_clr && !done_evt |=> !done_r)
        else $error("flags not cleared by command");
endmodule : sfrl_top

// [shared/sfrl_pkg.sv]
// Constants and types shared by the shift queue readback block
package sfrl_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int unsigned AW = 4;
    localparam int unsigned DW = 16;
    localparam int unsigned QW = 32;
    localparam int unsigned QH = 16;
    localparam int unsigned IW = 5;
    localparam int unsigned DLYW = 4;
    localparam int unsigned DLYD = 15;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [AW-1:0] ADDR_CFG = 4'h0;
    localparam logic [AW-1:0] ADDR_CNT = 4'h1;
    localparam logic [AW-1:0] ADDR_CMD = 4'h2;
    localparam logic [AW-1:0] ADDR_STAT = 4'h3;
    localparam logic [AW-1:0] ADDR_CAPL = 4'h4;
    localparam logic [AW-1:0] ADDR_CAPH = 4'h5;
    // ------------------------------------------------------------
    // Path configuration fields
    // ------------------------------------------------------------
    localparam int unsigned CFG_DLY = 0;
    localparam int unsigned CFG_LEN = 4;
    localparam int unsigned CFG_SRC = 5;
    localparam int unsigned CFG_SEL = 8;
    localparam int unsigned CFG_POST = 10;
    localparam int unsigned CFG_MSB = 11;
    localparam int unsigned CFG_EDGE = 12;
    localparam int unsigned CFG_EVT = 13;
    localparam logic [DW-1:0] CFG_MASK = 16'h3f7f;
    localparam logic [1:0] SRC_LOOP = 2'h0;
    localparam logic [1:0] SEL_QUEUE = 2'h2;
    // ------------------------------------------------------------
    // Command word fields
    // ------------------------------------------------------------
    localparam int unsigned CMD_TYPE = 12;
    localparam int unsigned CMD_START = 5;
    localparam int unsigned CMD_FLAG = 0;
    localparam logic [3:0] TYPE_CTRL = 4'h5;
    localparam logic [2:0] START_SCAN = 3'h4;
    localparam logic [3:0] FLAG_CLEAR = 4'h0;
    // ------------------------------------------------------------
    // Status bits and reset values
    // ------------------------------------------------------------
    localparam int unsigned ST_BUSY = 0;
    localparam int unsigned ST_DONE = 1;
    localparam logic [DW-1:0] CFG_RESET = 16'h0000;
    localparam logic [DW-1:0] CNT_RESET = 16'h000f;
    localparam logic [QW-1:0] QUEUE_RESET = 32'hffff_ffff;
    localparam logic [QW-1:0] CAP_RESET = 32'h0000_0000;
    typedef enum logic [1:0] {
        SFRL_IDLE = 2'b01,
        SFRL_SHIFT = 2'b10
    } sfrl_link_t;
endpackage : sfrl_pkg

// [rtl/sfrl_sync.sv]
// Two-stage level synchroniser
module sfrl_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= '0;
            q <= '0;
        end else begin
            s1_r <= d;
            q <= s1_r;
        end
    end
endmodule : sfrl_sync

// [rtl/sfrl_queue.sv]
// Serial shift queue, 16 or 32 positions, either bit order
module sfrl_queue (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic shift,
    input wire logic long_sel,
    input wire logic msb_first,
    input wire logic din,
    output logic [sfrl_pkg::QW-1:0] q,
    output logic dout
);
    logic [sfrl_pkg::QW-1:0] q_nxt;

    always_comb begin
        q_nxt = q;
        if (shift && !msb_first) begin
            q_nxt = {1'b0, q[sfrl_pkg::QW-1:1]};
            if (long_sel) begin
                q_nxt[sfrl_pkg::QW-1] = din;
            end else begin
                q_nxt[sfrl_pkg::QW-1:sfrl_pkg::QH] =
                    q[sfrl_pkg::QW-1:sfrl_pkg::QH];
                q_nxt[sfrl_pkg::QH-1] = din;
            end
        end else if (shift) begin
            q_nxt = {q[sfrl_pkg::QW-2:0], din};
            if (!long_sel) begin
                q_nxt[sfrl_pkg::QW-1:sfrl_pkg::QH] =
                    q[sfrl_pkg::QW-1:sfrl_pkg::QH];
            end
        end
    end

    // Head of the queue
    assign dout = !msb_first ? q[0] :
                  long_sel ? q[sfrl_pkg::QW-1] : q[sfrl_pkg::QH-1];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= sfrl_pkg::QUEUE_RESET;
        end else begin
            q <= q_nxt;
        end
    end
endmodule : sfrl_queue

// [verif/sfrl_chain_model.sv]
// Scan chain stand-in that drives the serial input pin
module sfrl_chain_model (
    input wire logic link_clk,
    input wire logic [1:0] mode,
    output logic tdi
);
    timeunit 1ns;
    timeprecision 100ps;
    logic tgl_r = 1'b0;
    // Launch on the trailing edge so the leading edge samples settled data
    always @(negedge link_clk) begin
        tgl_r <= ~tgl_r;
    end
    // Mode 2: line not held, changes every cycle so a wrong source shows
    assign tdi = (mode == 2'h2) ? tgl_r : mode[0];
endmodule : sfrl_chain_model

// [verif/sfrl_top_tb.sv]
// Self-checking bench for the shift queue readback loop
module sfrl_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock, link_clk, arst_n, reg_wr, reg_rd, link_tdo, link_tdi;
    logic [sfrl_pkg::AW-1:0] reg_addr;
    logic [sfrl_pkg::DW-1:0] reg_wdata, reg_rdata, rv, st;
    logic [1:0] mode;
    logic [31:0] mq;
    logic [3:0] ro_a [4] = '{4'h3, 4'h4, 4'h5, 4'hf};
    integer seed = 32'h4ee3f128;
    int failures = 0;
    int n_tests = 0;
    sfrl_top sfrl_top_i (.CLOCK(clock), .ARST_N(arst_n),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .LINK_CLK(link_clk),
        .LINK_TDI(link_tdi), .LINK_TDO(link_tdo));
    sfrl_chain_model sfrl_chain_model_i (.link_clk(link_clk),
        .mode(mode), .tdi(link_tdi));
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial begin
        link_clk = 1'b0;
        #7;
        forever #15 link_clk = ~link_clk;
    end
    // ------------------------------------------------------------
    // Checks and verdict
    // ------------------------------------------------------------
    task automatic finish_test;
        $display("Compares %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp,
                         input string what);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk16
    task automatic chk1(input logic got, input logic exp, input string what);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask : chk1
    // ------------------------------------------------------------
    // Register port and queue model
    // ------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    // Returns {capture, new queue}; capture bit i is the i-th bit out
    function automatic logic [63:0] model_scan(input logic [31:0] q,
        input int len, input int n, input logic loop, input logic b,
        input logic m);
        logic [31:0] cap;
        logic o, d;
        cap = 32'h0;
        for (int i = 0; i < n; i++) begin
            o = !m ? q[0] : (len == 32) ? q[31] : q[15];
            d = loop ? o : b;
            cap[i] = o;
            if (m && len == 32) begin
                q = {q[30:0], d};
            end else if (m) begin
                q[15:0] = {q[14:0], d};
            end else if (len == 32) begin
                q = {d, q[31:1]};
            end else begin
                q[15:0] = {d, q[15:1]};
            end
        end
        return {cap, q};
    endfunction : model_scan
    task automatic scan(input logic [15:0] cfg, input logic [15:0] cnt,
                        input logic [1:0] md);
        logic [63:0] res;
        logic [31:0] msk, cap;
        logic [15:0] s;
        int n, i;
        n = cnt[4:0] + 1;
        msk = (n == 32) ? 32'hffff_ffff : ((32'h1 << n) - 32'h1);
        res = model_scan(mq, cfg[sfrl_pkg::CFG_LEN] ? 32 : 16, n,
                         cfg[6:5] == sfrl_pkg::SRC_LOOP, md[0],
                         cfg[sfrl_pkg::CFG_MSB]);
        mode <= md;
        wr(sfrl_pkg::ADDR_CFG, cfg);
        wr(sfrl_pkg::ADDR_CNT, cnt);
        wr(sfrl_pkg::ADDR_CMD, 16'h5080);
        wr(sfrl_pkg::ADDR_CMD, 16'h5080);
        s = 16'h0;
        for (i = 0; i < 600 && s[1] !== 1'b1; i++) begin
            rd(sfrl_pkg::ADDR_STAT, s);
        end
        if (s[1] !== 1'b1) begin
            failures++;
            $display("BAD %0t scan never finished", $time);
            finish_test();
        end
        chk16(s, 16'h0002, "status at end");
        rd(sfrl_pkg::ADDR_CAPL, s);
        cap[15:0] = s;
        rd(sfrl_pkg::ADDR_CAPH, s);
        cap[31:16] = s;
        chk16(cap[15:0] & msk[15:0], res[47:32] & msk[15:0], "cap lo");
        chk16(cap[31:16] & msk[31:16], res[63:48] & msk[31:16], "cap hi");
        mq = res[31:0];
        wr(sfrl_pkg::ADDR_CMD, 16'h6000);
        rd(sfrl_pkg::ADDR_STAT, s);
        chk16(s, 16'h0000, "status cleared");
    endtask : scan
    task automatic do_reset;
        @(posedge clock);
        arst_n <= 1'b0;
        repeat (5) @(posedge clock);
        arst_n <= 1'b1;
        repeat (4) @(posedge link_clk);
        mq = sfrl_pkg::QUEUE_RESET;
    endtask : do_reset
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0;
        mode = 2'h2;
        arst_n = 1'b0;
        do_reset();
        #1 chk1(link_tdo, 1'b1, "idle output");
        for (int i = 0; i < 7; i++) begin
            rd((i == 6) ? 4'hf : 4'(i), rv);
            chk16(rv, (i == 1) ? sfrl_pkg::CNT_RESET : 16'h0, "reset");
        end
        foreach (ro_a[k]) begin
            wr(ro_a[k], 16'hffff);
            rd(ro_a[k], rv);
            chk16(rv, 16'h0000, "read-only");
        end
        repeat (4) begin
            rv = 16'($random(seed));
            wr(sfrl_pkg::ADDR_CFG, rv);
            rd(sfrl_pkg::ADDR_CFG, st);
            chk16(st, rv & sfrl_pkg::CFG_MASK, "cfg");
            wr(sfrl_pkg::ADDR_CNT, rv);
            rd(sfrl_pkg::ADDR_CNT, st);
            chk16(st, rv, "counter");
        end
        $display("Register test done");
        // Host order: 8-bit load, then readbacks of the short queue
        scan(16'h0620, 16'h0007, 2'h0);
        scan(16'h0600, 16'h000f, 2'h2);
        scan(16'h0600, 16'h000f, 2'h2);
        $display("Instruction load test done");
        scan(16'h0200, 16'h000f, 2'h2);
        scan(16'h0e00, 16'h000f, 2'h2);
        scan(16'h1620, 16'h0009, 2'h1);
        $display("Mode test done");
        repeat (4) begin
            rv = 16'($random(seed));
            scan(16'h0620, {12'h0, rv[3:0]}, {1'b0, rv[4]});
            scan(16'h0600, 16'h000f, 2'h2);
            chk1(link_tdo, mq[15], "output holds last bit");
        end
        $display("Random load test done");
        // 18-bit vector into the long queue after a second reset
        do_reset();
        scan(16'h0630, 16'h0011, 2'h0);
        scan(16'h0610, 16'h001f, 2'h2);
        $display("Long queue test done");
        wr(sfrl_pkg::ADDR_CFG, 16'h0100);
        repeat (20) @(posedge clock);
        #1 chk1(link_tdo, 1'b1, "select not queue");
        $display("Output select test done");
        finish_test();
    end
endmodule : sfrl_top_tb
